// [inc/gpb_defines.vh]
`ifndef GPB_DEFINES_VH
`define GPB_DEFINES_VH

// register indices, data-space; byte address is four times the index
`define GPB_IDX_F_PIN     8'h20
`define GPB_IDX_E_PIN     8'h21
`define GPB_IDX_E_DIR     8'h22
`define GPB_IDX_E_OUT     8'h23
`define GPB_IDX_D_PIN     8'h30
`define GPB_IDX_D_DIR     8'h31
`define GPB_IDX_D_OUT     8'h32
`define GPB_IDX_C_PIN     8'h33
`define GPB_IDX_C_DIR     8'h34
`define GPB_IDX_C_OUT     8'h35
`define GPB_IDX_B_PIN     8'h36
`define GPB_IDX_B_DIR     8'h37
`define GPB_IDX_F_DIR     8'h61
`define GPB_IDX_F_OUT     8'h62
`define GPB_IDX_G_OUT     8'h65

// io-space window and its distance to data space
`define GPB_IO_TOP        8'h20
`define GPB_IO_SHIFT      8'h20

// field layout
`define GPB_G_MSB         4
`define GPB_IDX_LSB       2
`define GPB_IDX_MSB       9

// reset values
`define GPB_RST_OUT       8'h00
`define GPB_RST_DIR       8'h00
`define GPB_RST_C_COMPAT  8'hff
`define GPB_RST_G         5'h00
`define GPB_RST_DATA      32'h0000_0000

`endif

// [design/gpb_top.v]
// Contract
// - compat mode: port C resets as push-pull outputs driving zero
// - compat port C reset state is set without any clock edge
// - compat mode: port F output and direction hidden from software
// - compat mode: port F pins are inputs only, drivers off
// - port G output holds bits 4..0; bits 7..5 read zero
// - port B input register read-only, returns pin levels through the two-stage synchroniser
// - port F direction: eight bits read/write, resets to zero
// - port F output: eight bits read/write, resets to zero
// - port E input register read-only, returns sampled pin levels
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`include "gpb_defines.vh"

module gpb_top #(
  parameter COMPAT_MODE = 0
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire [7:0]  pb_pin_in,
  input  wire [7:0]  pc_pin_in,
  input  wire [7:0]  pd_pin_in,
  input  wire [7:0]  pe_pin_in,
  input  wire [7:0]  pf_pin_in,
  output reg  [7:0]  pb_oe_n,
  output reg  [7:0]  pc_pin_out,
  output reg  [7:0]  pc_oe_n,
  output reg  [7:0]  pd_pin_out,
  output reg  [7:0]  pd_oe_n,
  output reg  [7:0]  pe_pin_out,
  output reg  [7:0]  pe_oe_n,
  output reg  [7:0]  pf_pin_out,
  output reg  [7:0]  pf_oe_n,
  output reg  [4:0]  pg_pin_out
);

  // compat reset constants chosen at build time, no clock needed
  localparam [7:0] C_DIR_RST = (COMPAT_MODE != 0) ?
                               `GPB_RST_C_COMPAT : `GPB_RST_DIR;
  localparam [7:0] C_OEN_RST = ~C_DIR_RST;
  localparam       COMPAT    = (COMPAT_MODE != 0);

  // pin synchronisers
  wire [39:0] pins_raw;
  reg  [39:0] sync1_q;
  reg  [39:0] sync2_q;

  assign pins_raw = {pb_pin_in, pc_pin_in, pd_pin_in, pe_pin_in, pf_pin_in};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q <= 40'h00_0000_0000;
      sync2_q <= 40'h00_0000_0000;
    end
    else
    begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire [7:0] pb_lvl;
  wire [7:0] pc_lvl;
  wire [7:0] pd_lvl;
  wire [7:0] pe_lvl;
  wire [7:0] pf_lvl;

  assign pb_lvl = sync2_q[39:32];
  assign pc_lvl = sync2_q[31:24];
  assign pd_lvl = sync2_q[23:16];
  assign pe_lvl = sync2_q[15:8];
  assign pf_lvl = sync2_q[7:0];

  // address phase decode
  wire [7:0] raw_idx;
  wire       addr_ok;
  wire       take;
  reg  [7:0] norm_idx;

  assign raw_idx = haddr[`GPB_IDX_MSB:`GPB_IDX_LSB];
  assign addr_ok = (haddr[31:10] == 22'h00_0000) &&
                   (haddr[1:0] == 2'b00);
  assign take    = hsel && hready && htrans[1];

  always @*
  begin
    if (raw_idx < `GPB_IO_TOP)
    begin
      norm_idx = raw_idx + `GPB_IO_SHIFT;
    end
    else
    begin
      norm_idx = raw_idx;
    end
  end

  // data phase state
  reg       wr_q;
  reg [7:0] idx_q;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q  <= 1'b0;
      idx_q <= 8'h00;
    end
    else
    begin
      wr_q  <= take && hwrite && addr_ok;
      idx_q <= norm_idx;
    end
  end

  // register storage
  reg [7:0] b_dir_q, b_dir_d;
  reg [7:0] c_out_q, c_out_d;
  reg [7:0] c_dir_q, c_dir_d;
  reg [7:0] d_out_q, d_out_d;
  reg [7:0] d_dir_q, d_dir_d;
  reg [7:0] e_out_q, e_out_d;
  reg [7:0] e_dir_q, e_dir_d;
  reg [7:0] f_out_q, f_out_d;
  reg [7:0] f_dir_q, f_dir_d;
  reg [4:0] g_out_q, g_out_d;

  wire [7:0] wbyte;
  assign wbyte = hwdata[7:0];

  always @*
  begin
    b_dir_d = b_dir_q;
    c_out_d = c_out_q;
    c_dir_d = c_dir_q;
    d_out_d = d_out_q;
    d_dir_d = d_dir_q;
    e_out_d = e_out_q;
    e_dir_d = e_dir_q;
    f_out_d = f_out_q;
    f_dir_d = f_dir_q;
    g_out_d = g_out_q;
    if (wr_q)
    begin
      if (idx_q == `GPB_IDX_B_DIR)
        b_dir_d = wbyte;
      else if (idx_q == `GPB_IDX_C_OUT)
        c_out_d = wbyte;
      else if (idx_q == `GPB_IDX_C_DIR)
        c_dir_d = wbyte;
      else if (idx_q == `GPB_IDX_D_OUT)
        d_out_d = wbyte;
      else if (idx_q == `GPB_IDX_D_DIR)
        d_dir_d = wbyte;
      else if (idx_q == `GPB_IDX_E_OUT)
        e_out_d = wbyte;
      else if (idx_q == `GPB_IDX_E_DIR)
        e_dir_d = wbyte;
      else if ((idx_q == `GPB_IDX_F_OUT) && !COMPAT)
        f_out_d = wbyte;
      else if ((idx_q == `GPB_IDX_F_DIR) && !COMPAT)
        f_dir_d = wbyte;
      else if (idx_q == `GPB_IDX_G_OUT)
        g_out_d = wbyte[`GPB_G_MSB:0];
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      b_dir_q <= `GPB_RST_DIR;
      c_out_q <= `GPB_RST_OUT;
      c_dir_q <= C_DIR_RST;
      d_out_q <= `GPB_RST_OUT;
      d_dir_q <= `GPB_RST_DIR;
      e_out_q <= `GPB_RST_OUT;
      e_dir_q <= `GPB_RST_DIR;
      f_out_q <= `GPB_RST_OUT;
      f_dir_q <= `GPB_RST_DIR;
      g_out_q <= `GPB_RST_G;
    end
    else
    begin
      b_dir_q <= b_dir_d;
      c_out_q <= c_out_d;
      c_dir_q <= c_dir_d;
      d_out_q <= d_out_d;
      d_dir_q <= d_dir_d;
      e_out_q <= e_out_d;
      e_dir_q <= e_dir_d;
      f_out_q <= f_out_d;
      f_dir_q <= f_dir_d;
      g_out_q <= g_out_d;
    end
  end

  // read mux over next values, so a write just before is seen
  reg [7:0] rd_byte;

  always @*
  begin
    if (norm_idx == `GPB_IDX_F_PIN)
      rd_byte = pf_lvl;
    else if (norm_idx == `GPB_IDX_E_PIN)
      rd_byte = pe_lvl;
    else if (norm_idx == `GPB_IDX_E_DIR)
      rd_byte = e_dir_d;
    else if (norm_idx == `GPB_IDX_E_OUT)
      rd_byte = e_out_d;
    else if (norm_idx == `GPB_IDX_D_PIN)
      rd_byte = pd_lvl;
    else if (norm_idx == `GPB_IDX_D_DIR)
      rd_byte = d_dir_d;
    else if (norm_idx == `GPB_IDX_D_OUT)
      rd_byte = d_out_d;
    else if (norm_idx == `GPB_IDX_C_PIN)
      rd_byte = pc_lvl;
    else if (norm_idx == `GPB_IDX_C_DIR)
      rd_byte = c_dir_d;
    else if (norm_idx == `GPB_IDX_C_OUT)
      rd_byte = c_out_d;
    else if (norm_idx == `GPB_IDX_B_PIN)
      rd_byte = pb_lvl;
    else if (norm_idx == `GPB_IDX_B_DIR)
      rd_byte = b_dir_d;
    else if ((norm_idx == `GPB_IDX_F_DIR) && !COMPAT)
      rd_byte = f_dir_d;
    else if ((norm_idx == `GPB_IDX_F_OUT) && !COMPAT)
      rd_byte = f_out_d;
    else if ((norm_idx == `GPB_IDX_G_OUT) && (raw_idx >= `GPB_IO_TOP))
      rd_byte = {3'b000, g_out_d};
    else
      rd_byte = 8'h00;
  end

  // bus answer: zero wait, always okay
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= `GPB_RST_DATA;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (take && !hwrite && addr_ok)
        hrdata <= {24'h00_0000, rd_byte};
      else if (take)
        hrdata <= `GPB_RST_DATA;
    end
  end

  // pin drivers, one cycle behind the registers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pb_oe_n    <= ~`GPB_RST_DIR;
      pc_pin_out <= `GPB_RST_OUT;
      pc_oe_n    <= C_OEN_RST;
      pd_pin_out <= `GPB_RST_OUT;
      pd_oe_n    <= ~`GPB_RST_DIR;
      pe_pin_out <= `GPB_RST_OUT;
      pe_oe_n    <= ~`GPB_RST_DIR;
      pf_pin_out <= `GPB_RST_OUT;
      pf_oe_n    <= ~`GPB_RST_DIR;
      pg_pin_out <= `GPB_RST_G;
    end
    else
    begin
      pb_oe_n    <= ~b_dir_q;
      pc_pin_out <= c_out_q;
      pc_oe_n    <= ~c_dir_q;
      pd_pin_out <= d_out_q;
      pd_oe_n    <= ~d_dir_q;
      pe_pin_out <= e_out_q;
      pe_oe_n    <= ~e_dir_q;
      pf_pin_out <= COMPAT ? `GPB_RST_OUT : f_out_q;
      pf_oe_n    <= COMPAT ? ~`GPB_RST_DIR : ~f_dir_q;
      pg_pin_out <= g_out_q;
    end
  end

endmodule // gpb_top

// [verification/gpb_sva.sv]
`timescale 1ns/1ps
module gpb_sva #(
  parameter COMPAT_MODE = 0
) (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire [7:0]  pe_pin_in,
  input wire [7:0]  pc_pin_out,
  input wire [7:0]  pc_oe_n,
  input wire [7:0]  pf_pin_out,
  input wire [7:0]  pf_oe_n,
  input wire [4:0]  pg_pin_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // address phase taken
  sequence s_ad(bit w, bit [7:0] i);
    hsel && hready && htrans[1] && hwrite == w && haddr == {22'h0, i, 2'h0};
  endsequence
  // write through its data phase
  sequence s_wr(bit [7:0] i);
    s_ad(1'h1, i) ##1 1'h1;
  endsequence
  property p_c_rst;
    disable iff (1'h0) !hresetn |-> pc_pin_out == 8'h00 &&
      pc_oe_n == (COMPAT_MODE ? 8'h00 : 8'hff);
  endproperty
  a_c_rst: assert property (p_c_rst) else $error("port c reset state");
  property p_f_in;
    (COMPAT_MODE != 0) |-> pf_oe_n == 8'hff && pf_pin_out == 8'h00;
  endproperty
  a_f_in: assert property (p_f_in) else $error("port f drives");
  property p_g_wr;
    s_wr(8'h65) |=> ##1 pg_pin_out == $past(hwdata[4:0], 2);
  endproperty
  a_g_wr: assert property (p_g_wr) else $error("port g out");
  property p_g_rd;
    s_ad(1'h0, 8'h65) |=> hrdata[7:5] == 3'h0;
  endproperty
  a_g_rd: assert property (p_g_rd) else $error("port g high bits");
  property p_f_out;
    s_wr(8'h62) |=> ##1 pf_pin_out ==
      (COMPAT_MODE ? 8'h00 : $past(hwdata[7:0], 2));
  endproperty
  a_f_out: assert property (p_f_out) else $error("port f out");
  property p_f_dir;
    s_wr(8'h61) |=> ##1 pf_oe_n ==
      (COMPAT_MODE ? 8'hff : ~$past(hwdata[7:0], 2));
  endproperty
  a_f_dir: assert property (p_f_dir) else $error("port f dir");
  property p_hide;
    s_ad(1'h0, 8'h62) |=> COMPAT_MODE == 0 || hrdata == 32'h0000_0000;
  endproperty
  a_hide: assert property (p_hide) else $error("port f visible");
  property p_e_pin;
    s_ad(1'h0, 8'h21) ##0 $stable(pe_pin_in) ##0 $past(hresetn, 2)
      ##0 pe_pin_in == $past(pe_pin_in, 2) |=> hrdata[7:0] == $past(pe_pin_in);
  endproperty
  a_e_pin: assert property (p_e_pin) else $error("port e pins");
endmodule // gpb_sva
bind gpb_top gpb_sva #(.COMPAT_MODE(COMPAT_MODE)) u_sva (.*);

// [verification/gpb_pins.sv]
`timescale 1ns/1ps
// board side of one port
module gpb_pins (
  input  wire [7:0] ext,
  input  wire [7:0] drv,
  input  wire [7:0] oe_n,
  output wire [7:0] lvl
);
  // driven bits follow the block, others the board
  assign lvl = (~oe_n & drv) | (oe_n & ext);
endmodule // gpb_pins

// [verification/gpb_top_tb.sv]
`timescale 1ns/1ps
module gpb_top_tb;
  logic hclk = 1'h0, run = 1'h1, hresetn = 1'h1, hsel = 1'h0;
  logic hwrite = 1'h0, hready, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd1;
  logic [7:0] pb_pin_in, pc_pin_in, pd_pin_in, pe_pin_in, pf_pin_in, pb_oe_n;
  logic [7:0] pc_pin_out, pc_oe_n, pd_pin_out, pd_oe_n, pe_pin_out, pe_oe_n;
  logic [7:0] pf_pin_out, pf_oe_n, c1o, c1d, f1o;
  logic [4:0] pg_pin_out;
  logic [7:0] ex [256] = '{default: 8'h5a};
  logic [15:0] s = 16'h0031;
  int m0 [256], m1 [256];
  int err_total = 0, n_compared = 0;
  int L [15] = '{'h20, 'h21, 'h22, 'h23, 'h30, 'h31, 'h32, 'h33, 'h34,
                 'h35, 'h36, 'h37, 'h61, 'h62, 'h65};
  int U [4] = '{'h45, 'h64, 'h7f, 'h122};
  always #4 if (run) hclk = ~hclk;
  assign hready = hreadyout;
  assign pb_pin_in = ex['h36];
  gpb_top DUT (.*);
  gpb_top #(.COMPAT_MODE(1)) DUT1 (.*, .hreadyout(), .hresp(), .hrdata(rd1),
    .pb_oe_n(), .pc_pin_out(c1d), .pc_oe_n(c1o), .pd_pin_out(), .pd_oe_n(),
    .pe_pin_out(), .pe_oe_n(), .pf_pin_out(), .pf_oe_n(f1o), .pg_pin_out());
  gpb_pins PC (.ext(ex['h33]), .drv(pc_pin_out), .oe_n(pc_oe_n), .lvl(pc_pin_in));
  gpb_pins PD (.ext(ex['h30]), .drv(pd_pin_out), .oe_n(pd_oe_n), .lvl(pd_pin_in));
  gpb_pins PE (.ext(ex['h21]), .drv(pe_pin_out), .oe_n(pe_oe_n), .lvl(pe_pin_in));
  gpb_pins PF (.ext(ex['h20]), .drv(pf_pin_out), .oe_n(pf_oe_n), .lvl(pf_pin_in));
  function logic [7:0] lf();
    s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    return s[7:0];
  endfunction
  // expected read value; pins seen through the non-compat copy
  function int ex_of(int i, bit c);
    int d;
    if (i > 'hff) return 0;
    if (i < 'h20) i += 'h20;
    d = (i == 'h20) ? 'h61 : i + 1;
    if (i == 'h36) return ex[i];
    if (i inside {'h20, 'h21, 'h30, 'h33})
      return (m0[d] & m0[d + 1]) | (~m0[d] & ex[i]);
    return c ? m1[i] : m0[i];
  endfunction
  task mwr(int i, int d);
    if (i < 'h20) i += 'h20;
    if (!(i inside {'h22, 'h23, 'h31, 'h32, 'h34, 'h35, 'h37, 'h61, 'h62, 'h65}))
      return;
    m0[i] = d & (i == 'h65 ? 'h1f : 'hff);
    if (i < 'h61 || i > 'h62) m1[i] = m0[i];
  endtask
  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task hs();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'h1 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      finish_test();
    end
  endtask
  task xf(bit w, int i, int d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= i * 4;
    hs();
    htrans <= 2'h0;
    hwdata <= d;
    hs();
  endtask
  task cmp(logic [31:0] g, logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk(int i);
    repeat (4) @(posedge hclk);
    xf(1'h0, i, lf());
    cmp(hrdata, ex_of(i, 0));
    cmp(rd1, ex_of(i, 1));
    cmp(pg_pin_out, m0['h65]);
    cmp(pb_oe_n, ~m0['h37] & 'hff);
    cmp({hresp, hreadyout}, 2'h1);
  endtask
  task rst();
    hresetn <= 1'h0;
    m0 = '{default: 0};
    m1 = '{default: 0};
    m1['h34] = 'hff;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
  endtask
  initial
  begin
    int i, d;
    rst();
    foreach (L[k]) chk(L[k]);
    $display("test reset values done");
    repeat (60)
    begin
      i = L[lf() % 15];
      if (i < 'h40 && lf() < 8'h80) i -= 'h20;
      d = {lf(), lf(), lf(), lf()};
      ex[L[lf() % 15]] <= lf();
      mwr(i, d);
      xf(1'h1, i, d);
      chk(i);
    end
    $display("test random access done");
    foreach (U[k])
    begin
      xf(1'h1, U[k], -1);
      chk(U[k]);
      chk(U[k] & 'hff);
    end
    $display("test unmapped done");
    run = 1'h0;
    #2 hresetn <= 1'h0;
    #20;
    cmp(c1o, 8'h00);
    cmp(c1d, 8'h00);
    cmp(pc_oe_n, 8'hff);
    cmp(f1o, 8'hff);
    run = 1'h1;
    rst();
    foreach (L[k]) chk(L[k]);
    $display("test stopped clock reset done");
    finish_test();
  end
endmodule // gpb_top_tb
